// [rtl/nvac_pkg.sv]
// Constants and types for the EEPROM access controller
// How it works
// - Data register holds the byte to program and receives read bytes.
// - Two-bit mode picks atomic, erase only or write only; 11 reserved.
// - Mode field writes are ignored while the write strobe is set.
// - Reset clears mode to zero unless programming is still running.
// - Ready interrupt is a level while strobe clear, flash self-programming idle, enables set.
// - Master write enable clears itself four clocks after being set.
// - Write strobe starts programming only while master enable is set.
// - No EEPROM programming starts while flash self-programming is busy.
// - Hardware clears the write strobe once programming time elapses.
// - Setting the write strobe stalls the core for two cycles.
// - Read strobe fetches the addressed byte into the data register.
// - A triggered read stalls the core for four cycles.
// - Atomic write counts 26,368 calibrated oscillator ticks; erase only or write only counts 13,184.
// - Registers answer at data offset and at offset minus 0x20.
// - Nine-bit address selects bytes 0 to 511 linearly.
package nvac_pkg;

  // Data-space offsets
  localparam logic [7:0] NVAC_OFS_CTRL = 8'h3f;
  localparam logic [7:0] NVAC_OFS_DATA = 8'h40;
  localparam logic [7:0] NVAC_OFS_ADDR_LO = 8'h41;
  localparam logic [7:0] NVAC_OFS_ADDR_HI = 8'h42;
  // Distance between data-space and I/O-space addresses
  localparam logic [7:0] NVAC_IO_OFFSET = 8'h20;

  // Control register bit positions
  localparam int NVAC_BIT_RE = 0;
  localparam int NVAC_BIT_PE = 1;
  localparam int NVAC_BIT_MWE = 2;
  localparam int NVAC_BIT_RIE = 3;
  localparam int NVAC_BIT_PM_LO = 4;
  localparam int NVAC_BIT_PM_HI = 5;

  // Reset values
  localparam logic [7:0] NVAC_DATA_RESET = 8'h00;
  localparam logic [8:0] NVAC_ADDR_RESET = 9'h000;
  localparam logic [7:0] NVAC_RDATA_NONE = 8'h00;

  // Widths
  localparam int NVAC_ADDR_W = 9;
  localparam int NVAC_TICK_W = 15;
  localparam int NVAC_SCNT_W = 3;

  // Cycle counts on the system clock
  localparam logic [NVAC_SCNT_W-1:0] NVAC_MWE_CYCLES = 3'h4;
  localparam logic [NVAC_SCNT_W-1:0] NVAC_WR_STALL = 3'h2;
  localparam logic [NVAC_SCNT_W-1:0] NVAC_RD_STALL = 3'h4;
  localparam logic [NVAC_SCNT_W-1:0] NVAC_SCNT_ONE = 3'h1;
  localparam logic [NVAC_SCNT_W-1:0] NVAC_SCNT_ZERO = 3'h0;

  // Oscillator tick counts for one programming action
  localparam int NVAC_ATOMIC_TICKS = 26368;
  localparam int NVAC_SPLIT_TICKS = 13184;
  localparam logic [NVAC_TICK_W-1:0] NVAC_TICK_ONE = 15'h0001;
  localparam logic [NVAC_TICK_W-1:0] NVAC_TICK_ZERO = 15'h0000;

  // Programming modes
  typedef enum logic [1:0] {
    NVAC_PM_ATOMIC = 2'b00,
    NVAC_PM_ERASE = 2'b01,
    NVAC_PM_WRITE = 2'b10,
    NVAC_PM_RSVD = 2'b11
  } nvac_pm_e;

  // Programming timer states
  typedef enum logic {
    NVAC_T_IDLE = 1'b0,
    NVAC_T_PROG = 1'b1
  } nvac_tstate_e;

endpackage

// [rtl/nvac_core_if.sv]
// Signals between the controller top and its timer and stall helpers
`timescale 1ns/1ps
`default_nettype none
interface nvac_core_if;
  import nvac_pkg::*;
  logic prog_start;
  nvac_pm_e prog_mode;
  logic prog_busy;
  logic stall_wr;
  logic stall_rd;
  logic stall;

  modport ctl (
    output prog_start,
    output prog_mode,
    output stall_wr,
    output stall_rd,
    input prog_busy,
    input stall
  );
  modport timer (
    input prog_start,
    input prog_mode,
    output prog_busy
  );
  modport stl (
    input stall_wr,
    input stall_rd,
    output stall
  );
endinterface
`default_nettype wire

// [rtl/nvac_prog_timer.sv]
// Programming duration timer paced by calibrated oscillator ticks
`timescale 1ns/1ps
`default_nettype none
module nvac_prog_timer
  import nvac_pkg::*;
#(
  parameter int ATOMIC_TICKS = NVAC_ATOMIC_TICKS,
  parameter int SPLIT_TICKS = NVAC_SPLIT_TICKS
) (
  input wire logic ref_clk,
  input wire logic por_n,
  input wire logic rc_tick,
  nvac_core_if.timer cif
);
  localparam logic [NVAC_TICK_W-1:0] ATOMIC_LD = NVAC_TICK_W'(ATOMIC_TICKS);
  localparam logic [NVAC_TICK_W-1:0] SPLIT_LD = NVAC_TICK_W'(SPLIT_TICKS);

  nvac_tstate_e state_q;
  logic [NVAC_TICK_W-1:0] cnt_q;

  // Only power-on clears it, so a system reset lets a write finish
  always_ff @(posedge ref_clk or negedge por_n) begin
    if (!por_n) begin
      state_q <= NVAC_T_IDLE;
      cnt_q <= NVAC_TICK_ZERO;
    end else begin
      case (state_q)
        NVAC_T_IDLE: begin
          if (cif.prog_start) begin
            state_q <= NVAC_T_PROG;
            cnt_q <= (cif.prog_mode == NVAC_PM_ATOMIC) ? ATOMIC_LD : SPLIT_LD;
          end
        end
        NVAC_T_PROG: begin
          if (rc_tick) begin
            if (cnt_q == NVAC_TICK_ONE) begin
              state_q <= NVAC_T_IDLE;
            end
            cnt_q <= cnt_q - NVAC_TICK_ONE;
          end
        end
        default: begin
          state_q <= NVAC_T_IDLE;
        end
      endcase
    end
  end

  assign cif.prog_busy = (state_q == NVAC_T_PROG);
endmodule
`default_nettype wire

// [rtl/nvac_stall_gen.sv]
// Core stall pulse generator for register-triggered accesses
`timescale 1ns/1ps
`default_nettype none
module nvac_stall_gen
  import nvac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  nvac_core_if.stl cif
);
  logic [NVAC_SCNT_W-1:0] cnt_q;

  // Reload on each trigger; a read wins since it stalls longer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= NVAC_SCNT_ZERO;
    end else if (cif.stall_rd) begin
      cnt_q <= NVAC_RD_STALL;
    end else if (cif.stall_wr) begin
      cnt_q <= NVAC_WR_STALL;
    end else if (cnt_q != NVAC_SCNT_ZERO) begin
      cnt_q <= cnt_q - NVAC_SCNT_ONE;
    end
  end

  assign cif.stall = (cnt_q != NVAC_SCNT_ZERO);
endmodule
`default_nettype wire

// [rtl/nvac_top.sv]
// EEPROM access controller: registers, write sequencing, read path
`timescale 1ns/1ps
`default_nettype none
module nvac_top
  import nvac_pkg::*;
#(
  parameter int ATOMIC_TICKS = NVAC_ATOMIC_TICKS,
  parameter int SPLIT_TICKS = NVAC_SPLIT_TICKS
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic por_n,
  input wire logic [7:0] io_addr,
  input wire logic io_space,
  input wire logic io_we,
  input wire logic io_re,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic global_irq_en,
  input wire logic self_program_busy,
  input wire logic rc_tick,
  output logic [NVAC_ADDR_W-1:0] arr_addr,
  output logic [7:0] arr_wdata,
  output logic arr_rd,
  input wire logic [7:0] arr_rdata,
  output logic arr_prog_busy,
  output logic [1:0] arr_prog_mode,
  output logic irq_ready,
  output logic cpu_stall
);

  // Reset synchroniser, async assert and clocked release
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Helpers joined through the shared interface
  nvac_core_if cif ();

  nvac_prog_timer #(
    .ATOMIC_TICKS(ATOMIC_TICKS),
    .SPLIT_TICKS(SPLIT_TICKS)
  ) u_timer (
    .ref_clk(ref_clk),
    .por_n(por_n),
    .rc_tick(rc_tick),
    .cif(cif.timer)
  );

  nvac_stall_gen u_stall (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .cif(cif.stl)
  );

  // Register state
  logic [7:0] data_q;
  logic [NVAC_ADDR_W-1:0] addr_q;
  nvac_pm_e mode_q;
  logic rie_q;
  logic mwe_q;
  logic [NVAC_SCNT_W-1:0] mwe_cnt_q;
  logic [7:0] rdata_q;
  logic busy;

  assign busy = cif.prog_busy;

  logic [7:0] eff_addr;
  assign eff_addr = io_space ? 8'(io_addr + NVAC_IO_OFFSET) : io_addr;

  // Write decode
  logic wr_ctrl;
  logic wr_data;
  logic wr_addr_lo;
  logic wr_addr_hi;
  assign wr_ctrl = io_we && (eff_addr == NVAC_OFS_CTRL);
  assign wr_data = io_we && (eff_addr == NVAC_OFS_DATA);
  assign wr_addr_lo = io_we && (eff_addr == NVAC_OFS_ADDR_LO);
  assign wr_addr_hi = io_we && (eff_addr == NVAC_OFS_ADDR_HI);

  // Mode carried by this write, used if it also starts programming
  nvac_pm_e mode_wr;
  assign mode_wr = nvac_pm_e'(io_wdata[NVAC_BIT_PM_HI:NVAC_BIT_PM_LO]);

  // Write start: enable must already be open, and flash must be idle
  logic start;
  always_comb begin
    start = wr_ctrl && io_wdata[NVAC_BIT_PE] && mwe_q;
    start = start && !self_program_busy && !busy;
    // Reserved mode never launches an action
    start = start && (mode_wr != NVAC_PM_RSVD);
  end

  logic rd_go;
  assign rd_go = wr_ctrl && io_wdata[NVAC_BIT_RE] && !busy;

  assign cif.prog_start = start;
  assign cif.prog_mode = mode_wr;
  assign cif.stall_wr = start;
  assign cif.stall_rd = rd_go;

  // Master write enable with self-timeout
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mwe_q <= 1'b0;
      mwe_cnt_q <= NVAC_SCNT_ZERO;
    end else if (wr_ctrl) begin
      mwe_q <= io_wdata[NVAC_BIT_MWE];
      mwe_cnt_q <= io_wdata[NVAC_BIT_MWE] ? NVAC_MWE_CYCLES : NVAC_SCNT_ZERO;
    end else if (mwe_q) begin
      if (mwe_cnt_q == NVAC_SCNT_ONE) begin
        mwe_q <= 1'b0;
      end
      mwe_cnt_q <= mwe_cnt_q - NVAC_SCNT_ONE;
    end
  end

  // Mode field; survives a system reset taken mid-write
  always_ff @(posedge ref_clk or negedge por_n) begin
    if (!por_n) begin
      mode_q <= NVAC_PM_ATOMIC;
    end else if (!rst_n) begin
      if (!busy) begin
        mode_q <= NVAC_PM_ATOMIC;
      end
    end else if (wr_ctrl && !busy) begin
      mode_q <= mode_wr;
    end
  end

  // Ready interrupt enable
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rie_q <= 1'b0;
    end else if (wr_ctrl) begin
      rie_q <= io_wdata[NVAC_BIT_RIE];
    end
  end

  // Data register; like the mode field it outlives a reset mid-write
  always_ff @(posedge ref_clk or negedge por_n) begin
    if (!por_n) begin
      data_q <= NVAC_DATA_RESET;
    end else if (!rst_n) begin
      if (!busy) begin
        data_q <= NVAC_DATA_RESET;
      end
    end else if (rd_go) begin
      data_q <= arr_rdata;
    end else if (wr_data && !busy) begin
      data_q <= io_wdata;
    end
  end

  // Nine-bit linear address; frozen while a write runs, reset included
  always_ff @(posedge ref_clk or negedge por_n) begin
    if (!por_n) begin
      addr_q <= NVAC_ADDR_RESET;
    end else if (!rst_n) begin
      if (!busy) begin
        addr_q <= NVAC_ADDR_RESET;
      end
    end else if (!busy) begin
      if (wr_addr_lo) begin
        addr_q[7:0] <= io_wdata;
      end
      if (wr_addr_hi) begin
        addr_q[NVAC_ADDR_W-1] <= io_wdata[0];
      end
    end
  end

  // Control readback; strobe bit mirrors the running write
  logic [7:0] ctrl_view;
  always_comb begin
    ctrl_view = NVAC_RDATA_NONE;
    ctrl_view[NVAC_BIT_PM_HI:NVAC_BIT_PM_LO] = mode_q;
    ctrl_view[NVAC_BIT_RIE] = rie_q;
    ctrl_view[NVAC_BIT_MWE] = mwe_q;
    ctrl_view[NVAC_BIT_PE] = busy;
  end

  // Registered read port, unmapped addresses read zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= NVAC_RDATA_NONE;
    end else if (io_re) begin
      case (eff_addr)
        NVAC_OFS_CTRL: rdata_q <= ctrl_view;
        NVAC_OFS_DATA: rdata_q <= data_q;
        NVAC_OFS_ADDR_LO: rdata_q <= addr_q[7:0];
        NVAC_OFS_ADDR_HI: rdata_q <= {7'h00, addr_q[NVAC_ADDR_W-1]};
        default: rdata_q <= NVAC_RDATA_NONE;
      endcase
    end
  end

  // Array side
  assign arr_addr = addr_q;
  assign arr_wdata = data_q;
  assign arr_rd = rd_go;
  assign arr_prog_busy = busy;
  assign arr_prog_mode = mode_q;
  assign io_rdata = rdata_q;

  assign irq_ready = rie_q && global_irq_en && !busy && !self_program_busy;

  assign cpu_stall = cif.stall;
endmodule
`default_nettype wire

// [verif/nvac_mem_model.sv]
// Behavioural EEPROM array on the far side of the controller
`timescale 1ns/1ps
`default_nettype none
module nvac_mem_model (
  input wire logic ref_clk,
  input wire logic [8:0] arr_addr,
  input wire logic [7:0] arr_wdata,
  input wire logic arr_rd,
  input wire logic arr_prog_busy,
  input wire logic [1:0] arr_prog_mode,
  output logic [7:0] arr_rdata
);
  logic [7:0] mem [512];
  logic busy_q;
  // Each cell starts at its own low address byte
  initial begin
    for (int i = 0; i < 512; i++) mem[i] = i[7:0];
    busy_q = 1'b0;
  end
  // linear read
  // Outside a read the bus shows the inverse, so stale captures show
  assign arr_rdata = arr_rd ? mem[arr_addr] : ~mem[arr_addr];
  always @(posedge ref_clk) begin
    busy_q <= arr_prog_busy;
    if (busy_q && !arr_prog_busy) begin
      case (arr_prog_mode)
        2'b00: mem[arr_addr] <= arr_wdata;
        2'b01: mem[arr_addr] <= 8'hff;
        default: mem[arr_addr] <= mem[arr_addr] & arr_wdata;
      endcase
    end
  end
endmodule
`default_nettype wire

// [verif/nvac_chk.sv]
// Port-level assertions for the EEPROM access controller
`timescale 1ns/1ps
`default_nettype none
module nvac_chk
  import nvac_pkg::*;
#(
  parameter int ATOMIC_TICKS = NVAC_ATOMIC_TICKS,
  parameter int SPLIT_TICKS = NVAC_SPLIT_TICKS
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic por_n,
  input wire logic rc_tick,
  input wire logic global_irq_en,
  input wire logic self_program_busy,
  input wire logic [NVAC_ADDR_W-1:0] arr_addr,
  input wire logic [7:0] arr_wdata,
  input wire logic arr_rd,
  input wire logic arr_prog_busy,
  input wire logic [1:0] arr_prog_mode,
  input wire logic irq_ready,
  input wire logic cpu_stall
);
  logic [15:0] tick_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Ticks counted while programming; power-on only, so a write that
  // spans a system reset is still counted whole
  always_ff @(posedge ref_clk or negedge por_n) begin
    if (!por_n) tick_q <= 16'h0000;
    else tick_q <= arr_prog_busy ? tick_q + 16'(rc_tick) : 16'h0000;
  end
  irq_gate_a: assert property (
    irq_ready |-> global_irq_en && !arr_prog_busy && !self_program_busy)
    else $error("ready request while busy or masked");
  rd_stall_a: assert property (
    arr_rd |=> cpu_stall [*4] ##1 !cpu_stall)
    else $error("read stall not four cycles");
  wr_stall_a: assert property (
    $rose(arr_prog_busy) |-> cpu_stall [*2] ##1 !cpu_stall)
    else $error("write stall not two cycles");
  busy_read_a: assert property (arr_prog_busy |-> !arr_rd)
    else $error("array read during programming");
  hold_addr_a: assert property (
    arr_prog_busy && $past(arr_prog_busy) |->
      $stable(arr_addr) && $stable(arr_wdata))
    else $error("address or data moved while programming");
  hold_mode_a: assert property (
    arr_prog_busy && $past(arr_prog_busy) |-> $stable(arr_prog_mode))
    else $error("mode moved while programming");
  flash_idle_a: assert property (
    $rose(arr_prog_busy) |-> !$past(self_program_busy))
    else $error("programming began during flash write");
  no_rsvd_a: assert property (arr_prog_busy |-> arr_prog_mode != 2'b11)
    else $error("reserved mode started programming");
  prog_time_a: assert property (
    $fell(arr_prog_busy) |-> tick_q ==
      ((arr_prog_mode == 2'b00) ? ATOMIC_TICKS : SPLIT_TICKS))
    else $error("programming length wrong");
endmodule
`default_nettype wire

// [verif/eeprom_access_control_tb.sv]
// Register-level testbench for the EEPROM access controller
`timescale 1ns/1ps
`default_nettype none
module eeprom_access_control_tb;
  import nvac_pkg::*;
  logic ref_clk = 0, nrst = 0, por_n = 0, rc_tick = 0;
  logic io_space = 0, io_we = 0, io_re = 0;
  logic global_irq_en = 0, self_program_busy = 0;
  logic [7:0] io_addr = 8'h00, io_wdata = 8'h00;
  logic [7:0] io_rdata, arr_wdata, arr_rdata, rv, e;
  logic [8:0] arr_addr, a;
  logic [1:0] arr_prog_mode;
  logic arr_rd, arr_prog_busy, irq_ready, cpu_stall;
  int fails = 0, cmp_count = 0;
  nvac_top #(.ATOMIC_TICKS(20), .SPLIT_TICKS(10)) uut (.ref_clk(ref_clk),
    .nrst(nrst), .por_n(por_n), .io_addr(io_addr), .io_space(io_space),
    .io_we(io_we), .io_re(io_re), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .global_irq_en(global_irq_en), .self_program_busy(self_program_busy),
    .rc_tick(rc_tick), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
    .arr_rd(arr_rd), .arr_rdata(arr_rdata), .arr_prog_busy(arr_prog_busy),
    .arr_prog_mode(arr_prog_mode), .irq_ready(irq_ready),
    .cpu_stall(cpu_stall));
  nvac_mem_model mem_i (.ref_clk(ref_clk), .arr_addr(arr_addr),
    .arr_wdata(arr_wdata), .arr_rd(arr_rd), .arr_prog_busy(arr_prog_busy),
    .arr_prog_mode(arr_prog_mode), .arr_rdata(arr_rdata));
  // 250 MHz clock, one oscillator tick every fourth cycle
  initial forever #2 ref_clk = ~ref_clk;
  initial forever begin
    repeat (3) @(posedge ref_clk);
    #1 rc_tick = 1;
    @(posedge ref_clk);
    #1 rc_tick = 0;
  end
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge ref_clk);
    #1 io_addr = ad;
    io_wdata = d;
    io_we = 1;
    @(posedge ref_clk);
    #1 io_we = 0;
  endtask
  task rd(input logic [7:0] ad, output logic [7:0] d);
    @(posedge ref_clk);
    #1 io_addr = ad;
    io_re = 1;
    @(posedge ref_clk);
    #1 io_re = 0;
    d = io_rdata;
  endtask
  task setad(input logic [8:0] x);
    wr(NVAC_OFS_ADDR_LO, x[7:0]);
    wr(NVAC_OFS_ADDR_HI, {7'h00, x[8]});
  endtask
  // Poll the write strobe with a bound, then expect it clear
  task wait_idle;
    int n;
    n = 0;
    do begin
      rd(NVAC_OFS_CTRL, rv);
      n++;
    end while (rv[1] !== 1'b0 && n < 200);
    chk(rv & 8'h02, 8'h00);
  endtask
  // Watchdog well past the expected run length
  initial begin
    #100000;
    fails++;
    stop_test;
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    #1 nrst = 1;
    por_n = 1;
    repeat (3) @(posedge ref_clk);
    rd(NVAC_OFS_CTRL, rv); chk(rv, 8'h00);
    rd(NVAC_OFS_DATA, rv); chk(rv, 8'h00);
    rd(8'h50, rv); chk(rv, 8'h00);
    io_space = 1;
    wr(8'h20, 8'ha5);
    wr(8'h1f, 8'h08);
    rd(8'h1f, rv); chk(rv, 8'h08);
    rd(8'h20, rv); chk(rv, 8'ha5);
    wr(8'h1f, 8'h00);
    io_space = 0;
    rd(NVAC_OFS_DATA, rv); chk(rv, 8'ha5);
    $display("test registers done");
    for (int m = 0; m < 3; m++) begin
      global_irq_en = 0;
      a = 9'h100 + 9'(m);
      e = m == 0 ? 8'h3c : m == 1 ? 8'hff : (a[7:0] & 8'h3c);
      setad(a);
      wr(NVAC_OFS_DATA, 8'h3c);
      wr(NVAC_OFS_CTRL, 8'h0c | 8'(m << 4));
      chk({7'h00, irq_ready}, 8'h00);
      wr(NVAC_OFS_CTRL, 8'h0e | 8'(m << 4));
      global_irq_en = 1;
      // Mode, data, address and read strobe are all refused while busy
      wr(NVAC_OFS_DATA, 8'h00);
      wr(NVAC_OFS_ADDR_LO, 8'h77);
      wr(NVAC_OFS_CTRL, 8'h39);
      chk({7'h00, irq_ready}, 8'h00);
      rd(NVAC_OFS_CTRL, rv); chk(rv & 8'h32, 8'h02 | 8'(m << 4));
      wait_idle;
      chk({7'h00, irq_ready}, 8'h01);
      rd(NVAC_OFS_DATA, rv); chk(rv, 8'h3c);
      setad(a);
      wr(NVAC_OFS_CTRL, 8'h01);
      chk({7'h00, irq_ready}, 8'h00);
      rd(NVAC_OFS_DATA, rv); chk(rv, e);
    end
    $display("test programming modes done");
    // System reset in mid-write: mode, address and data must survive
    // interrupts off
    global_irq_en = 0;
    setad(9'h0a5);
    wr(NVAC_OFS_DATA, 8'h5a);
    wr(NVAC_OFS_CTRL, 8'h04);
    wr(NVAC_OFS_CTRL, 8'h16);
    @(posedge ref_clk);
    #1 nrst = 0;
    repeat (6) @(posedge ref_clk);
    #1 nrst = 1;
    repeat (3) @(posedge ref_clk);
    rd(NVAC_OFS_CTRL, rv); chk(rv & 8'h3e, 8'h12);
    rd(NVAC_OFS_DATA, rv); chk(rv, 8'h5a);
    wait_idle;
    setad(9'h0a5);
    wr(NVAC_OFS_CTRL, 8'h01);
    rd(NVAC_OFS_DATA, rv); chk(rv, 8'hff);
    $display("test reset during write done");
    // Reserved mode, timed-out enable, flash busy, missing enable
    for (int k = 0; k < 4; k++) begin
      self_program_busy = (k == 2);
      wr(NVAC_OFS_CTRL, k == 3 ? 8'h00 : k == 0 ? 8'h34 : 8'h04);
      repeat (k == 1 ? 6 : 0) @(posedge ref_clk);
      wr(NVAC_OFS_CTRL, k == 0 ? 8'h36 : 8'h06);
      rd(NVAC_OFS_CTRL, rv); chk(rv & 8'h02, 8'h00);
    end
    self_program_busy = 0;
    $display("test refused starts done");
    stop_test;
  end
endmodule
bind nvac_top nvac_chk #(.ATOMIC_TICKS(ATOMIC_TICKS),
  .SPLIT_TICKS(SPLIT_TICKS)) chk_i (.ref_clk(ref_clk), .nrst(nrst),
  .por_n(por_n), .rc_tick(rc_tick), .global_irq_en(global_irq_en),
  .self_program_busy(self_program_busy), .arr_addr(arr_addr),
  .arr_wdata(arr_wdata), .arr_rd(arr_rd), .arr_prog_busy(arr_prog_busy),
  .arr_prog_mode(arr_prog_mode), .irq_ready(irq_ready),
  .cpu_stall(cpu_stall));
`default_nettype wire
